// ### design/spcp_control_page.sv
// port control page: AXI4-Lite register bank and applied port settings
`include "spcp_defs.svh"

module spcp_control_page (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`SPCP_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`SPCP_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // PHY scan results per port
  input wire logic [`SPCP_NPORTS-1:0] phy_link,
  input wire logic [`SPCP_NPORTS-1:0][1:0] phy_speed,
  input wire logic [`SPCP_NPORTS-1:0] phy_duplex,
  input wire logic [`SPCP_NPORTS-1:0] phy_tx_pause,
  input wire logic [`SPCP_NPORTS-1:0] phy_rx_pause,
  // applied port state
  output logic [`SPCP_NPORTS-1:0] port_link,
  output logic [`SPCP_NPORTS-1:0][1:0] port_speed,
  output logic [`SPCP_NPORTS-1:0] port_duplex,
  output logic [`SPCP_NPORTS-1:0] port_tx_pause,
  output logic [`SPCP_NPORTS-1:0] port_rx_pause,
  output logic turbo_mii_function,
  // management port and scan configuration
  output logic rx_clock_delay_on,
  output logic tx_clock_delay_on,
  output logic [4:0] wan_phy_poll_addr,
  output logic [4:0] mgmt_port_poll_addr,
  // global controls
  output logic soft_reset_active,
  output logic pause_skip_dest_check
);

  spcp_pkg::spcp_regs_t r_ff;
  spcp_pkg::spcp_regs_t nxt_r;

  logic have_aw;
  logic have_w;
  logic do_write;
  logic [`SPCP_ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic [`SPCP_IDX_W-1:0] wr_idx;
  logic do_read;
  logic [`SPCP_NPORTS-1:0] turbo_vec;

  // ==========================================================
  // decode helpers
  function automatic logic [`SPCP_IDX_W-1:0] to_idx(
    input logic [`SPCP_ADDR_W-1:0] a
  );
    to_idx = a[`SPCP_ADDR_W-1:2];
  endfunction

  // port number of an override index, or NPORTS when none matches
  function automatic int ovr_port(input logic [`SPCP_IDX_W-1:0] idx);
    ovr_port = `SPCP_NPORTS;
    for (int p = 0; p < `SPCP_NPORTS; p++) begin
      if (idx == `SPCP_IDX_OVR_BASE + `SPCP_IDX_W'(p)) begin
        ovr_port = p;
      end
    end
  endfunction

  // read value of one index; hit low for an unmapped word
  function automatic logic [8:0] read_reg(
    input spcp_pkg::spcp_regs_t s,
    input logic [`SPCP_IDX_W-1:0] idx
  );
    int p;
    p = ovr_port(idx);
    // reserved bits read as zero
    read_reg = {1'b1, 8'h00};
    if (p < `SPCP_NPORTS) begin
      read_reg[6:0] = s.ovr[p];
    end else begin
      case (idx)
        `SPCP_IDX_RGMII: begin
          read_reg[`SPCP_RGMII_RXC] = s.rx_delay;
          read_reg[`SPCP_RGMII_TXC] = s.tx_delay;
        end
        `SPCP_IDX_WAN_POLL: read_reg[4:0] = s.wan_poll;
        `SPCP_IDX_MGMT_POLL: read_reg[4:0] = s.mgmt_poll;
        `SPCP_IDX_SRST: begin
          read_reg[`SPCP_SRST_TRIG] = s.srst_trig;
          read_reg[`SPCP_SRST_GATE] = s.srst_gate;
        end
        `SPCP_IDX_PAUSE: read_reg[`SPCP_PAUSE_SKIP] = s.pause_skip;
        default: read_reg = 9'h000;
      endcase
    end
  endfunction

  // ==========================================================
  // write channel bookkeeping
  assign have_aw = !r_ff.aw_free || awvalid;
  assign have_w = !r_ff.w_free || wvalid;
  assign do_write = have_aw && have_w && !r_ff.bvalid;
  assign wr_addr = r_ff.aw_free ? awaddr : r_ff.awaddr;
  assign wr_byte = r_ff.w_free ? wdata[7:0] : r_ff.wdata;
  assign wr_lane0 = r_ff.w_free ? wstrb[0] : r_ff.wlane0;
  assign wr_idx = to_idx(wr_addr);
  assign do_read = arvalid && r_ff.ar_free;

  // ==========================================================
  // next state
  always_comb begin
    int p;
    logic [8:0] rd;
    logic hit;
    p = ovr_port(wr_idx);
    rd = read_reg(r_ff, to_idx(araddr));
    hit = 1'b0;
    nxt_r = r_ff;
    if (r_ff.aw_free && awvalid) begin
      nxt_r.aw_free = 1'b0;
      nxt_r.awaddr = awaddr;
    end
    if (r_ff.w_free && wvalid) begin
      nxt_r.w_free = 1'b0;
      nxt_r.wdata = wdata[7:0];
      nxt_r.wlane0 = wstrb[0];
    end
    if (do_write) begin
      // reserved bits are not stored, so whatever software writes there
      // has no effect
      if (p < `SPCP_NPORTS) begin
        hit = 1'b1;
        if (wr_lane0) begin
          nxt_r.ovr[p] = wr_byte[6:0];
        end
      end else begin
        hit = 1'b1;
        case (wr_idx)
          `SPCP_IDX_RGMII: if (wr_lane0) begin
            nxt_r.rx_delay = wr_byte[`SPCP_RGMII_RXC];
            nxt_r.tx_delay = wr_byte[`SPCP_RGMII_TXC];
          end
          `SPCP_IDX_WAN_POLL: if (wr_lane0) begin
            nxt_r.wan_poll = wr_byte[4:0];
          end
          `SPCP_IDX_MGMT_POLL: if (wr_lane0) begin
            nxt_r.mgmt_poll = wr_byte[4:0];
          end
          `SPCP_IDX_SRST: if (wr_lane0) begin
            // level bit: held until software writes it back to 0
            nxt_r.srst_trig = wr_byte[`SPCP_SRST_TRIG];
            nxt_r.srst_gate = wr_byte[`SPCP_SRST_GATE];
          end
          `SPCP_IDX_PAUSE: if (wr_lane0) begin
            nxt_r.pause_skip = wr_byte[`SPCP_PAUSE_SKIP];
          end
          default: hit = 1'b0;
        endcase
      end
      nxt_r.aw_free = 1'b0;
      nxt_r.w_free = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = hit ? `SPCP_RESP_OKAY : `SPCP_RESP_SLVERR;
    end else if (r_ff.bvalid && bready) begin
      nxt_r.bvalid = 1'b0;
      nxt_r.aw_free = 1'b1;
      nxt_r.w_free = 1'b1;
    end
    if (do_read) begin
      nxt_r.ar_free = 1'b0;
      nxt_r.rvalid = 1'b1;
      nxt_r.rdata = {24'h000000, rd[7:0]};
      nxt_r.rresp = rd[8] ? `SPCP_RESP_OKAY : `SPCP_RESP_SLVERR;
    end else if (r_ff.rvalid && rready) begin
      nxt_r.rvalid = 1'b0;
      nxt_r.ar_free = 1'b1;
    end
    nxt_r.srst_out = r_ff.srst_trig && r_ff.srst_gate;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_ff <= '0;
      r_ff.aw_free <= 1'b1;
      r_ff.w_free <= 1'b1;
      r_ff.ar_free <= 1'b1;
      for (int i = 0; i < `SPCP_NPORTS; i++) begin
        r_ff.ovr[i] <= `SPCP_OVR_RST;
      end
      r_ff.wan_poll <= `SPCP_WAN_POLL_RST;
      r_ff.mgmt_poll <= `SPCP_MGMT_POLL_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================
  // per-port selection
  for (genvar g = 0; g < `SPCP_NPORTS; g++) begin : g_port
    spcp_port_apply #(
      .TURBO_CAPABLE(g == `SPCP_TURBO_PORT)
    ) u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .ovr_cfg(r_ff.ovr[g]),
      .phy_link(phy_link[g]),
      .phy_speed(phy_speed[g]),
      .phy_duplex(phy_duplex[g]),
      .phy_tx_pause(phy_tx_pause[g]),
      .phy_rx_pause(phy_rx_pause[g]),
      .eff_link(port_link[g]),
      .eff_speed(port_speed[g]),
      .eff_duplex(port_duplex[g]),
      .eff_tx_pause(port_tx_pause[g]),
      .eff_rx_pause(port_rx_pause[g]),
      .turbo_mii_function(turbo_vec[g])
    );
  end

  assign turbo_mii_function = turbo_vec[`SPCP_TURBO_PORT];

  // ==========================================================
  // outputs
  assign awready = r_ff.aw_free;
  assign wready = r_ff.w_free;
  assign bvalid = r_ff.bvalid;
  assign bresp = r_ff.bresp;
  assign arready = r_ff.ar_free;
  assign rvalid = r_ff.rvalid;
  assign rdata = r_ff.rdata;
  assign rresp = r_ff.rresp;
  assign rx_clock_delay_on = r_ff.rx_delay;
  assign tx_clock_delay_on = r_ff.tx_delay;
  assign wan_phy_poll_addr = r_ff.wan_poll;
  assign mgmt_port_poll_addr = r_ff.mgmt_poll;
  assign soft_reset_active = r_ff.srst_out;
  assign pause_skip_dest_check = r_ff.pause_skip;

  // ==========================================================
  // checks
  a_srst_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_reset_active == $past(r_ff.srst_trig && r_ff.srst_gate))
    else $error("soft reset not gated by its enable");
  a_srst_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_ff.srst_trig && !do_write) |=> r_ff.srst_trig)
    else $error("soft reset bit cleared itself");
  a_delay_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_lane0 && wr_idx == `SPCP_IDX_RGMII) |=>
    ##1 (rx_clock_delay_on == $past(wr_byte[`SPCP_RGMII_RXC], 2)) &&
        (tx_clock_delay_on == $past(wr_byte[`SPCP_RGMII_TXC], 2)))
    else $error("clock delay bits not written");
  a_poll_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_lane0 && wr_idx == `SPCP_IDX_WAN_POLL) |=>
    wan_phy_poll_addr == $past(wr_byte[4:0]))
    else $error("wan poll address not written");
  a_pause_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_lane0 && wr_idx == `SPCP_IDX_PAUSE) |=>
    pause_skip_dest_check == $past(wr_byte[`SPCP_PAUSE_SKIP]))
    else $error("pause option not written");
  a_top_port_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_lane0 &&
     wr_idx == `SPCP_IDX_OVR_BASE + `SPCP_IDX_W'(`SPCP_NPORTS - 1)) |=>
    r_ff.ovr[`SPCP_NPORTS-1] == $past(wr_byte[6:0]))
    else $error("last port override byte misplaced");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_read |=> rvalid && !arready)
    else $error("read not answered next cycle");

endmodule // spcp_control_page

// ### design/spcp_defs.svh
// register offsets, field positions, reset values and codes of the page
`ifndef SPCP_DEFS_SVH
`define SPCP_DEFS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define SPCP_ADDR_W 12
`define SPCP_IDX_W 10
`define SPCP_IDX_OVR_BASE 10'h058
`define SPCP_IDX_RGMII 10'h060
`define SPCP_IDX_WAN_POLL 10'h075
`define SPCP_IDX_MGMT_POLL 10'h078
`define SPCP_IDX_SRST 10'h079
`define SPCP_IDX_PAUSE 10'h080
`define SPCP_NPORTS 6
`define SPCP_TURBO_PORT 5

// ==========================================================
// field positions
`define SPCP_OVR_APPLY 6
`define SPCP_OVR_TXFC 5
`define SPCP_OVR_RXFC 4
`define SPCP_OVR_SPD_HI 3
`define SPCP_OVR_SPD_LO 2
`define SPCP_OVR_DUPLEX 1
`define SPCP_OVR_LINK 0
`define SPCP_RGMII_RXC 1
`define SPCP_RGMII_TXC 0
`define SPCP_SRST_TRIG 7
`define SPCP_SRST_GATE 4
`define SPCP_PAUSE_SKIP 0

// ==========================================================
// reset values and codes
`define SPCP_OVR_RST 7'h0b
`define SPCP_WAN_POLL_RST 5'h15
`define SPCP_MGMT_POLL_RST 5'h18
`define SPCP_SPD_10 2'h0
`define SPCP_SPD_100 2'h1
`define SPCP_SPD_1000 2'h2
`define SPCP_SPD_TURBO 2'h3
`define SPCP_RESP_OKAY 2'h0
`define SPCP_RESP_SLVERR 2'h2

`endif

// ### design/spcp_pkg.sv
// types of the port control page
`include "spcp_defs.svh"

package spcp_pkg;

  // ==========================================================
  // state of the register bank and its bus slave
  typedef struct packed {
    logic aw_free;
    logic [`SPCP_ADDR_W-1:0] awaddr;
    logic w_free;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_free;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [`SPCP_NPORTS-1:0][6:0] ovr;
    logic rx_delay;
    logic tx_delay;
    logic [4:0] wan_poll;
    logic [4:0] mgmt_poll;
    logic srst_trig;
    logic srst_gate;
    logic pause_skip;
    logic srst_out;
  } spcp_regs_t;

  // ==========================================================
  // state of one port's applied settings
  typedef struct packed {
    logic link;
    logic [1:0] speed;
    logic duplex;
    logic tx_pause;
    logic rx_pause;
    logic turbo;
  } spcp_port_t;

endpackage

// ### design/spcp_port_apply.sv
// one port: picks software override or PHY results, registered
`include "spcp_defs.svh"

module spcp_port_apply #(
  parameter bit TURBO_CAPABLE = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // software override byte
  input wire logic [6:0] ovr_cfg,
  // results of the PHY scan
  input wire logic phy_link,
  input wire logic [1:0] phy_speed,
  input wire logic phy_duplex,
  input wire logic phy_tx_pause,
  input wire logic phy_rx_pause,
  // applied port state
  output logic eff_link,
  output logic [1:0] eff_speed,
  output logic eff_duplex,
  output logic eff_tx_pause,
  output logic eff_rx_pause,
  output logic turbo_mii_function
);

  spcp_pkg::spcp_port_t st_ff;
  spcp_pkg::spcp_port_t nxt_st;
  logic apply;
  logic [1:0] ovr_speed;

  assign apply = ovr_cfg[`SPCP_OVR_APPLY];
  assign ovr_speed = ovr_cfg[`SPCP_OVR_SPD_HI:`SPCP_OVR_SPD_LO];

  // ==========================================================
  // selection
  always_comb begin
    nxt_st = st_ff;
    if (apply) begin
      nxt_st.link = ovr_cfg[`SPCP_OVR_LINK];
      nxt_st.duplex = ovr_cfg[`SPCP_OVR_DUPLEX];
      nxt_st.speed = ovr_speed;
      nxt_st.tx_pause = ovr_cfg[`SPCP_OVR_TXFC];
      nxt_st.rx_pause = ovr_cfg[`SPCP_OVR_RXFC];
      // only the turbo-capable port turns code 11 into 200 Mbps
      nxt_st.turbo = TURBO_CAPABLE && (ovr_speed == `SPCP_SPD_TURBO);
    end else begin
      nxt_st.link = phy_link;
      nxt_st.duplex = phy_duplex;
      nxt_st.speed = phy_speed;
      nxt_st.tx_pause = phy_tx_pause;
      nxt_st.rx_pause = phy_rx_pause;
      nxt_st.turbo = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign eff_link = st_ff.link;
  assign eff_speed = st_ff.speed;
  assign eff_duplex = st_ff.duplex;
  assign eff_tx_pause = st_ff.tx_pause;
  assign eff_rx_pause = st_ff.rx_pause;
  assign turbo_mii_function = st_ff.turbo;

  // ==========================================================
  // checks
  a_ovr_link_duplex: assert property (@(posedge aclk) disable iff (!aresetn)
    apply |=> (eff_link == $past(ovr_cfg[`SPCP_OVR_LINK])) &&
              (eff_duplex == $past(ovr_cfg[`SPCP_OVR_DUPLEX])))
    else $error("override link or duplex not applied");
  a_ovr_pause: assert property (@(posedge aclk) disable iff (!aresetn)
    apply |=> (eff_tx_pause == $past(ovr_cfg[`SPCP_OVR_TXFC])) &&
              (eff_rx_pause == $past(ovr_cfg[`SPCP_OVR_RXFC])))
    else $error("override flow control not applied");
  a_ovr_speed: assert property (@(posedge aclk) disable iff (!aresetn)
    apply |=> eff_speed == $past(ovr_speed))
    else $error("override speed not applied");
  a_turbo_only: assert property (@(posedge aclk) disable iff (!aresetn)
    turbo_mii_function |-> TURBO_CAPABLE && $past(apply) &&
                           eff_speed == `SPCP_SPD_TURBO)
    else $error("turbo mode without its cause");
  a_phy_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    !apply |=> (eff_link == $past(phy_link)) &&
               (eff_speed == $past(phy_speed)) && !turbo_mii_function)
    else $error("phy results not passed through");

endmodule // spcp_port_apply

// ### verification/spcp_control_page_tb_top.sv
// self-checking bench for the port control page register bank
`include "spcp_defs.svh"

module spcp_control_page_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic aclk, aresetn;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [`SPCP_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [`SPCP_NPORTS-1:0] phy_link, phy_duplex, phy_tx_pause, phy_rx_pause;
  logic [`SPCP_NPORTS-1:0][1:0] phy_speed;
  logic [`SPCP_NPORTS-1:0] port_link, port_duplex, port_tx_pause;
  logic [`SPCP_NPORTS-1:0] port_rx_pause;
  logic [`SPCP_NPORTS-1:0][1:0] port_speed;
  logic turbo_mii_function, rx_clock_delay_on, tx_clock_delay_on;
  logic [4:0] wan_phy_poll_addr, mgmt_port_poll_addr;
  logic soft_reset_active, pause_skip_dest_check;
  logic [`SPCP_NPORTS-1:0] e_link, e_dup, e_tx, e_rx;
  logic [`SPCP_NPORTS-1:0][1:0] e_spd;
  logic [6:0] ovs [`SPCP_NPORTS];
  int n_errors, n_tests, cyc;
  localparam logic [7:0] SRD [6] = '{8'h80, 8'h90, 8'h10, 8'h90, 8'h80, 8'h00};
  localparam logic SRE [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  spcp_control_page uut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .phy_link(phy_link), .phy_speed(phy_speed), .phy_duplex(phy_duplex),
    .phy_tx_pause(phy_tx_pause), .phy_rx_pause(phy_rx_pause),
    .port_link(port_link), .port_speed(port_speed),
    .port_duplex(port_duplex), .port_tx_pause(port_tx_pause),
    .port_rx_pause(port_rx_pause), .turbo_mii_function(turbo_mii_function),
    .rx_clock_delay_on(rx_clock_delay_on),
    .tx_clock_delay_on(tx_clock_delay_on),
    .wan_phy_poll_addr(wan_phy_poll_addr),
    .mgmt_port_poll_addr(mgmt_port_poll_addr),
    .soft_reset_active(soft_reset_active),
    .pause_skip_dest_check(pause_skip_dest_check)
  );

  always #5 aclk = ~aclk;

  // ==========================================================
  // helpers
  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // reserved bits are always sent as zero
  task automatic axi_write(input logic [9:0] i, input logic [7:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= ba(i);
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic axi_read(input logic [9:0] i, input logic [31:0] ed,
                          input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= ba(i);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // port outputs lag a register write by two edges
  task automatic settle();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic chk_ports();
    // flags and speeds checked apart so that each fits one compare word
    chk("port_flags", {8'h00, e_link, e_dup, e_tx, e_rx},
        {8'h00, port_link, port_duplex, port_tx_pause, port_rx_pause});
    chk("port_speed", {20'h00000, e_spd}, {20'h00000, port_speed});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang is cut short well beyond the few hundred cycles needed
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("timeout at cycle %0d", cyc);
      finish_test();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    phy_link = 6'h2d;
    phy_duplex = 6'h1a;
    phy_tx_pause = 6'h33;
    phy_rx_pause = 6'h0c;
    phy_speed = 12'he4b;
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and pass-through of PHY results
    settle();
    {e_link, e_spd, e_dup, e_tx, e_rx} = {phy_link, phy_speed, phy_duplex,
                                          phy_tx_pause, phy_rx_pause};
    chk_ports();
    chk("turbo", 32'h0, {31'h0, turbo_mii_function});
    chk("wan_poll", 32'h15, {27'h0, wan_phy_poll_addr});
    chk("mgmt_poll", 32'h18, {27'h0, mgmt_port_poll_addr});
    chk("delays", 32'h0, {30'h0, rx_clock_delay_on, tx_clock_delay_on});
    chk("soft_rst", 32'h0, {31'h0, soft_reset_active});
    chk("pause_skip", 32'h0, {31'h0, pause_skip_dest_check});
    for (int p = 0; p < `SPCP_NPORTS; p++) begin
      axi_read(`SPCP_IDX_OVR_BASE + 10'(p), 32'h0b, 2'h0);
    end
    axi_read(`SPCP_IDX_RGMII, 32'h0, 2'h0);
    axi_read(`SPCP_IDX_WAN_POLL, 32'h15, 2'h0);
    axi_read(`SPCP_IDX_MGMT_POLL, 32'h18, 2'h0);
    axi_read(`SPCP_IDX_SRST, 32'h0, 2'h0);
    axi_read(`SPCP_IDX_PAUSE, 32'h0, 2'h0);
    axi_read(10'h3ff, 32'h0, 2'h2);
    axi_write(10'h3ff, 8'h01, 4'h1, 2'h2);
    $display("test reset_values done");
    // override on every port, PHY driving the opposite values
    for (int p = 0; p < `SPCP_NPORTS; p++) begin
      ovs[p] = {1'b1, p[0], ~p[0], (p == 5) ? 2'h3 : 2'(p % 3), p[1], ~p[1]};
      {e_tx[p], e_rx[p], e_spd[p], e_dup[p], e_link[p]} = ovs[p][5:0];
    end
    @(posedge aclk);
    {phy_link, phy_speed, phy_duplex, phy_tx_pause, phy_rx_pause} <=
      ~{e_link, e_spd, e_dup, e_tx, e_rx};
    for (int p = 0; p < `SPCP_NPORTS; p++) begin
      axi_write(`SPCP_IDX_OVR_BASE + 10'(p), {1'b0, ovs[p]}, 4'h1, 2'h0);
    end
    settle();
    chk_ports();
    chk("turbo", 32'h1, {31'h0, turbo_mii_function});
    for (int p = 0; p < `SPCP_NPORTS; p++) begin
      axi_read(`SPCP_IDX_OVR_BASE + 10'(p), {25'h0, ovs[p]}, 2'h0);
    end
    // lane 0 strobe low leaves the byte alone
    axi_write(`SPCP_IDX_OVR_BASE + 10'h1, 8'h00, 4'he, 2'h0);
    axi_read(`SPCP_IDX_OVR_BASE + 10'h1, {25'h0, ovs[1]}, 2'h0);
    // port 5 back to 1000, port 0 override withdrawn
    axi_write(`SPCP_IDX_OVR_BASE + 10'h5, 8'h48, 4'h1, 2'h0);
    axi_write(`SPCP_IDX_OVR_BASE, {2'h0, ovs[0][5:0]}, 4'h1, 2'h0);
    e_spd[5] = 2'h2;
    {e_tx[5], e_rx[5], e_dup[5], e_link[5]} = 4'h0;
    {e_link[0], e_spd[0], e_dup[0], e_tx[0], e_rx[0]} = {phy_link[0],
      phy_speed[0], phy_duplex[0], phy_tx_pause[0], phy_rx_pause[0]};
    settle();
    chk_ports();
    chk("turbo", 32'h0, {31'h0, turbo_mii_function});
    $display("test port_override done");
    // management clock delays
    for (int i = 0; i < 4; i++) begin
      axi_write(`SPCP_IDX_RGMII, 8'(i), 4'h1, 2'h0);
      settle();
      chk("delays", 32'(i), {30'h0, rx_clock_delay_on, tx_clock_delay_on});
      axi_read(`SPCP_IDX_RGMII, 32'(i), 2'h0);
    end
    $display("test clock_delay done");
    // poll addresses
    axi_write(`SPCP_IDX_WAN_POLL, 8'h0a, 4'h1, 2'h0);
    axi_write(`SPCP_IDX_MGMT_POLL, 8'h1f, 4'h1, 2'h0);
    settle();
    chk("wan_poll", 32'h0a, {27'h0, wan_phy_poll_addr});
    chk("mgmt_poll", 32'h1f, {27'h0, mgmt_port_poll_addr});
    axi_read(`SPCP_IDX_WAN_POLL, 32'h0a, 2'h0);
    axi_read(`SPCP_IDX_MGMT_POLL, 32'h1f, 2'h0);
    $display("test poll_address done");
    // soft reset needs both trigger and gate, and stays until cleared
    for (int i = 0; i < 6; i++) begin
      axi_write(`SPCP_IDX_SRST, SRD[i], 4'h1, 2'h0);
      settle();
      chk("soft_rst", {31'h0, SRE[i]}, {31'h0, soft_reset_active});
      axi_read(`SPCP_IDX_SRST, {24'h0, SRD[i]}, 2'h0);
    end
    $display("test soft_reset done");
    // pause destination check option
    for (int i = 1; i >= 0; i--) begin
      axi_write(`SPCP_IDX_PAUSE, 8'(i), 4'h1, 2'h0);
      settle();
      chk("pause_skip", 32'(i), {31'h0, pause_skip_dest_check});
      axi_read(`SPCP_IDX_PAUSE, 32'(i), 2'h0);
    end
    $display("test pause_check done");
    finish_test();
  end

endmodule // spcp_control_page_tb_top
